// ### sfpi_defs.vh
// Summary of operation
// RULE1 - Deselect enters standby; running internal cycle finishes
// RULE2 - Deselected: inputs ignored, outputs tristated
// RULE3 - Dedicated reset pin works while deselected
// RULE4 - Select low activates device for a command
// RULE5 - Host gives select falling edge before commands
// RULE6 - Command bits sampled on clock rising edges
// RULE7 - Single rate: sample rising, drive falling
// RULE8 - Double rate: sample and drive both edges
// RULE9 - Reset low resets and tristates outputs
// RULE10 - Reset during internal operation abandons it
// RULE11 - Config bit 4 can disable reset
// RULE12 - Shared-line reset inactive in four-line protocol
// RULE13 - Pause suspends traffic, tristates, ignores inputs
// RULE14 - Config bit 4 can disable pause
// RULE15 - Shared-line pause off in quad or double rate
// RULE16 - Protect pin low refuses protected program/erase
// RULE17 - Host sets status bit 7 for pin protection
// RULE18 - Single-line: line 0 in, line 1 out
// RULE19 - Dual: lines 0,1 bidirectional, 2,3 unused
// RULE20 - Quad: all four lines bidirectional
// RULE21 - Host holds shared line 3 high otherwise
`ifndef SFPI_DEFS_VH
`define SFPI_DEFS_VH
// ==========================================================
// Register byte offsets
`define SFPI_A_CTRL 8'h00
`define SFPI_A_NVCFG 8'h04
`define SFPI_A_EVCFG 8'h08
`define SFPI_A_STAT 8'h0c
`define SFPI_A_OP 8'h10
`define SFPI_A_TX 8'h14
`define SFPI_A_INFO 8'h18
// ==========================================================
// Reset values
`define SFPI_CTRL_RST 8'h00
`define SFPI_CFG_RST 8'h10
`define SFPI_SR_RST 8'ha0
`define SFPI_TX_RST 8'h00
// ==========================================================
// Field positions
`define SFPI_CFG_FN 4
`define SFPI_SR_SRWD 7
`define SFPI_SR_TB 5
`define SFPI_INFO_RST 26
`define SFPI_INFO_REF 27
`define SFPI_INFO_LOST 28
// ==========================================================
// Protocol and line width codes
`define SFPI_PROTO_EXT 2'h0
`define SFPI_PROTO_DUAL 2'h1
`define SFPI_PROTO_QUAD 2'h2
// Line three sharing variants
`define SFPI_DQ3_NONE 0
`define SFPI_DQ3_RST 1
`define SFPI_DQ3_PAUSE 2
// ==========================================================
// Timing
`define SFPI_OP_CYCLES 1000
`endif

// ### sfpi_top.v
// Register access over AHB-Lite and the register offsets were left to the implementer.
`include "sfpi_defs.vh"

module sfpi_top #(
  parameter DQ3_FUNC = `SFPI_DQ3_PAUSE,
  parameter HAS_RST_PIN = 1,
  parameter OP_CYCLES = `SFPI_OP_CYCLES
) (
  // Clock and reset
  input wire CORE_CLK_I,
  input wire RSTN_I,
  // AHB-Lite slave
  input wire HSEL_I,
  input wire [31:0] HADDR_I,
  input wire [1:0] HTRANS_I,
  input wire HWRITE_I,
  input wire [2:0] HSIZE_I,
  input wire [31:0] HWDATA_I,
  input wire HREADY_I,
  output reg [31:0] HRDATA_O,
  output reg HREADYOUT_O,
  output reg HRESP_O,
  // Flash pins
  input wire SEL_N_I,
  input wire SCLK_I,
  input wire RESET_N_I,
  input wire PAUSE_N_I,
  input wire WP_N_I,
  input wire [3:0] DQ_I,
  output reg [3:0] DQ_O,
  output reg [3:0] DQ_OE_O
);

  // ==========================================================
  // Local codes
  localparam PH_IDLE = 2'h0;
  localparam PH_CMD = 2'h1;
  localparam PH_IN = 2'h2;
  localparam PH_OUT = 2'h3;
  localparam CW = $clog2(OP_CYCLES + 1);
  // Counter load, cut to the counter width
  localparam [31:0] OP_LAST32 = OP_CYCLES - 1;
  localparam [CW-1:0] OP_LAST = OP_LAST32[CW-1:0];

  // ==========================================================
  // Pin synchronisers
  reg [8:0] s1_r; // First stage only
  reg [8:0] s2_r; // Second stage, safe to read
  reg sclk_d_r; // Clock history for edges
  reg sel_d_r; // Select history for edges

  // Two flops per pin before any logic
  always @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      // Idle pin levels: clock rests low, others high
      s1_r <= 9'h17f;
      s2_r <= 9'h17f;
      sclk_d_r <= 1'b0;
      sel_d_r <= 1'b1;
    end else begin
      s1_r <= {SEL_N_I, SCLK_I, RESET_N_I, PAUSE_N_I, WP_N_I, DQ_I};
      s2_r <= s1_r;
      sclk_d_r <= s2_r[7];
      sel_d_r <= s2_r[8];
    end
  end

  wire sel_n = s2_r[8];
  wire sclk = s2_r[7];
  wire rpin_n = s2_r[6];
  wire ppin_n = s2_r[5];
  wire wp_n = s2_r[4];
  wire [3:0] dq = s2_r[3:0];
  wire rise = sclk & ~sclk_d_r; // Serial clock rising
  wire fall = ~sclk & sclk_d_r; // Serial clock falling
  wire sel_fall = ~sel_n & sel_d_r; // Select asserted

  // ==========================================================
  // Software registers
  reg [7:0] ctrl_r; // Protocol, width class, rate
  reg [7:0] nvcfg_r; // Nonvolatile config copy
  reg [7:0] evcfg_r; // Enhanced volatile config
  reg [7:0] sr_r; // Status: protect and lock bits
  reg [7:0] tx_r; // Byte sent in output phase
  reg [7:0] inb_r; // Input bytes before output
  reg ref_f_r; // Sticky: operation refused
  reg rst_f_r; // Sticky: pin reset seen
  reg lost_f_r; // Sticky: operation abandoned

  wire [1:0] proto = ctrl_r[1:0];
  wire [1:0] cls = ctrl_r[3:2];
  wire ddr = ctrl_r[4];
  wire quad = (proto == `SFPI_PROTO_QUAD);
  // Function disabled by a zero in either copy
  wire fn_en = nvcfg_r[`SFPI_CFG_FN] & evcfg_r[`SFPI_CFG_FN]; // RULE11 RULE14

  // ==========================================================
  // Reset and pause qualification
  // Line three carries data when a x4 data class is set in the extended protocol
  wire x4_cls = (proto == `SFPI_PROTO_EXT) && (cls == `SFPI_PROTO_QUAD);
  wire ded_rst = (HAS_RST_PIN != 0) && fn_en && !rpin_n; // RULE3 RULE11
  wire dq3_rst = (DQ3_FUNC == `SFPI_DQ3_RST) && fn_en && !quad &&
                 !x4_cls && !sel_n && !dq[3]; // RULE12 RULE20
  wire pin_rst = ded_rst | dq3_rst; // RULE9
  wire p_dq3 = (DQ3_FUNC == `SFPI_DQ3_PAUSE) && !quad && !x4_cls &&
               !ddr && !dq[3]; // RULE15 RULE20
  wire p_ded = (DQ3_FUNC != `SFPI_DQ3_PAUSE) && !ppin_n;
  wire paused = !sel_n && fn_en && (p_dq3 | p_ded); // RULE13 RULE14
  // Only a selected, unpaused, unreset device drives the data lines
  wire active = !sel_n && !pin_rst && !paused; // RULE2 RULE13

  // ==========================================================
  // Line width selection
  function [2:0] wsel;
    input [1:0] code;
    begin
      case (code)
        `SFPI_PROTO_DUAL: wsel = 3'd2;
        `SFPI_PROTO_QUAD: wsel = 3'd4;
        default: wsel = 3'd1;
      endcase
    end
  endfunction

  wire [2:0] w_cmd = wsel(proto); // Command phase lines
  wire [2:0] w_dat = (proto == `SFPI_PROTO_EXT) ? wsel(cls) : wsel(proto);

  // ==========================================================
  // Serial engine state
  reg [1:0] ph_r; // Transfer phase
  reg [7:0] sh_r; // Input shifter
  reg [3:0] bits_r; // Bits in current byte
  reg [7:0] cmd_r; // Last command byte
  reg [7:0] rxb_r; // Last input byte
  reg [7:0] rxcnt_r; // Input bytes this frame
  reg [7:0] txsh_r; // Output shifter
  reg drv_r; // First output edge seen
  reg [3:0] dq_nxt; // Next output levels

  wire [2:0] w_now = (ph_r == PH_CMD) ? w_cmd : w_dat;
  // Command sampled on rising only; data also falling at double rate
  wire smp = (ph_r == PH_CMD) ? rise : (rise | (fall & ddr)); // RULE6 RULE7 RULE8
  // Output driven on falling, also rising at double rate
  wire drv = fall | (rise & ddr); // RULE7 RULE8
  wire [7:0] sh_in = (w_now == 3'd1) ? {sh_r[6:0], dq[0]} :
                     (w_now == 3'd2) ? {sh_r[5:0], dq[1:0]} :
                     {sh_r[3:0], dq};
  wire [3:0] bits_add = bits_r + {1'b0, w_now};
  wire [7:0] rxcnt_inc = rxcnt_r + 8'h01;
  // Lines that may drive per width
  wire [3:0] oe_mask = (w_dat == 3'd1) ? 4'b0010 :
                       (w_dat == 3'd2) ? 4'b0011 : 4'b1111; // RULE18 RULE19 RULE20

  // Output line levels from the shifter
  always @* begin
    dq_nxt = 4'h0;
    if (w_dat == 3'd1) begin
      dq_nxt[1] = txsh_r[7]; // RULE18
    end else if (w_dat == 3'd2) begin
      dq_nxt[1:0] = txsh_r[7:6]; // RULE19
    end else begin
      dq_nxt = txsh_r[7:4]; // RULE20
    end
  end

  // Frame engine: command, input bytes, then output bytes
  always @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ph_r <= PH_IDLE;
      sh_r <= 8'h00;
      bits_r <= 4'h0;
      cmd_r <= 8'h00;
      rxb_r <= 8'h00;
      rxcnt_r <= 8'h00;
      txsh_r <= 8'h00;
      drv_r <= 1'b0;
      DQ_O <= 4'h0;
      DQ_OE_O <= 4'h0;
    end else begin
      // Lines released unless actively driving; enable rises together
      // with the first output bits so the host never sees a gap
      DQ_OE_O <= (ph_r == PH_OUT && (drv_r || drv) && active) ?
                 oe_mask : 4'h0; // RULE2 RULE9 RULE13
      if (pin_rst || sel_n) begin
        // Deselect or reset ends the frame
        ph_r <= PH_IDLE; // RULE1 RULE9
        bits_r <= 4'h0;
        drv_r <= 1'b0;
      end else if (ph_r == PH_IDLE) begin
        // Frame opens only on a select falling edge
        if (sel_fall) begin
          ph_r <= PH_CMD; // RULE4 RULE5
          bits_r <= 4'h0;
          rxcnt_r <= 8'h00;
        end
      end else if (!paused) begin
        if (ph_r != PH_OUT && smp) begin
          sh_r <= sh_in;
          if (bits_add >= 4'd8) begin
            bits_r <= 4'h0;
            if (ph_r == PH_CMD) begin
              // Command done
              cmd_r <= sh_in;
              if (inb_r == 8'h00) begin
                ph_r <= PH_OUT;
                txsh_r <= tx_r;
              end else begin
                ph_r <= PH_IN;
              end
            end else begin
              // Input byte done
              rxb_r <= sh_in;
              rxcnt_r <= rxcnt_inc;
              if (rxcnt_inc == inb_r) begin
                ph_r <= PH_OUT;
                txsh_r <= tx_r;
              end
            end
          end else begin
            bits_r <= bits_add;
          end
        end else if (ph_r == PH_OUT && drv) begin
          // Output: present bits, then shift
          DQ_O <= dq_nxt;
          drv_r <= 1'b1;
          if (bits_add >= 4'd8) begin
            bits_r <= 4'h0;
            txsh_r <= tx_r;
          end else begin
            bits_r <= bits_add;
            txsh_r <= txsh_r << w_dat;
          end
        end
      end
    end
  end

  // ==========================================================
  // AHB-Lite slave
  reg wr_pend_r; // Write data phase pending
  reg [7:0] wa_r; // Captured write offset
  reg [31:0] rd_mux; // Read data for address

  wire a_go = HSEL_I && HTRANS_I[1] && HREADY_I;
  wire wr_now = wr_pend_r;
  wire wr_op = wr_now && (wa_r == `SFPI_A_OP) && HWDATA_I[0];
  wire wr_info = wr_now && (wa_r == `SFPI_A_INFO);

  // ==========================================================
  // Internal program/erase cycle
  reg busy_r; // Internal cycle running
  reg [CW-1:0] opcnt_r; // Cycles remaining
  reg [3:0] tsec_r; // Target region of last start
  wire [3:0] bp = {sr_r[6], sr_r[4:2]}; // block_protect_bits
  wire [3:0] tsec = HWDATA_I[7:4];
  wire [4:0] nprot = (bp == 4'h0) ? 5'd0 :
                     (bp >= 4'h5) ? 5'd16 :
                     (5'd1 << (bp - 4'h1));
  wire in_prot = sr_r[`SFPI_SR_TB] ? ({1'b0, tsec} < nprot) :
                 ({1'b0, tsec} >= (5'd16 - nprot));
  wire refuse = wr_op && !busy_r && !wp_n && in_prot; // RULE16
  wire lose = busy_r && pin_rst; // RULE10

  // Cycle counter ignores select; only reset stops it
  always @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      busy_r <= 1'b0;
      opcnt_r <= {CW{1'b0}};
      tsec_r <= 4'h0;
    end else if (lose) begin
      busy_r <= 1'b0; // RULE10
    end else if (busy_r) begin
      // Runs on through deselect
      if (opcnt_r == {CW{1'b0}}) begin
        busy_r <= 1'b0; // RULE1
      end else begin
        opcnt_r <= opcnt_r - {{(CW-1){1'b0}}, 1'b1};
      end
    end else if (wr_op && !refuse) begin
      busy_r <= 1'b1;
      opcnt_r <= OP_LAST;
      tsec_r <= tsec;
    end
  end

  // Read data selection by offset
  always @* begin
    rd_mux = 32'h0;
    if (HADDR_I[7:0] == `SFPI_A_CTRL) begin
      rd_mux[7:0] = ctrl_r;
    end else if (HADDR_I[7:0] == `SFPI_A_NVCFG) begin
      rd_mux[7:0] = nvcfg_r;
    end else if (HADDR_I[7:0] == `SFPI_A_EVCFG) begin
      rd_mux[7:0] = evcfg_r;
    end else if (HADDR_I[7:0] == `SFPI_A_STAT) begin
      rd_mux[7:0] = {sr_r[7:2], 1'b0, busy_r};
      rd_mux[8] = sel_n && !busy_r; // Standby
    end else if (HADDR_I[7:0] == `SFPI_A_OP) begin
      rd_mux[7:4] = tsec_r;
      rd_mux[8] = busy_r;
    end else if (HADDR_I[7:0] == `SFPI_A_TX) begin
      rd_mux[15:0] = {inb_r, tx_r};
    end else if (HADDR_I[7:0] == `SFPI_A_INFO) begin
      rd_mux[23:0] = {rxcnt_r, rxb_r, cmd_r};
      rd_mux[24] = !sel_n;
      rd_mux[25] = paused;
      rd_mux[`SFPI_INFO_RST] = rst_f_r;
      rd_mux[`SFPI_INFO_REF] = ref_f_r;
      rd_mux[`SFPI_INFO_LOST] = lost_f_r;
    end
  end

  // Address phase capture, zero wait, always OKAY
  always @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      wr_pend_r <= 1'b0;
      wa_r <= 8'h00;
      HRDATA_O <= 32'h0;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end else begin
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
      wr_pend_r <= a_go && HWRITE_I;
      if (a_go) begin
        wa_r <= HADDR_I[7:0];
        HRDATA_O <= HWRITE_I ? 32'h0 : rd_mux;
      end
    end
  end

  // Register writes and sticky flags, set wins over clear
  always @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ctrl_r <= `SFPI_CTRL_RST;
      nvcfg_r <= `SFPI_CFG_RST;
      evcfg_r <= `SFPI_CFG_RST;
      sr_r <= `SFPI_SR_RST;
      tx_r <= `SFPI_TX_RST;
      inb_r <= 8'h00;
      ref_f_r <= 1'b0;
      rst_f_r <= 1'b0;
      lost_f_r <= 1'b0;
    end else begin
      if (wr_now) begin
        if (wa_r == `SFPI_A_CTRL) begin
          ctrl_r <= HWDATA_I[7:0];
        end else if (wa_r == `SFPI_A_NVCFG) begin
          nvcfg_r <= HWDATA_I[7:0];
        end else if (wa_r == `SFPI_A_EVCFG) begin
          evcfg_r <= HWDATA_I[7:0];
        end else if (wa_r == `SFPI_A_STAT) begin
          // Locked while protect bit set and pin low
          if (!(sr_r[`SFPI_SR_SRWD] && !wp_n)) begin
            sr_r <= {HWDATA_I[7:2], 2'b00};
          end
        end else if (wa_r == `SFPI_A_TX) begin
          tx_r <= HWDATA_I[7:0];
          inb_r <= HWDATA_I[15:8];
        end
      end
      ref_f_r <= refuse |
                 (ref_f_r & ~(wr_info & HWDATA_I[`SFPI_INFO_REF]));
      rst_f_r <= pin_rst |
                 (rst_f_r & ~(wr_info & HWDATA_I[`SFPI_INFO_RST]));
      lost_f_r <= lose |
                  (lost_f_r & ~(wr_info & HWDATA_I[`SFPI_INFO_LOST]));
    end
  end

endmodule

// ### sfpi_properties.sv
// ========================================
// Port checker for the flash pin block
module sfpi_props (
  // Clock and reset
  input wire CORE_CLK_I,
  input wire RSTN_I,
  // Register bus
  input wire HSEL_I,
  input wire [31:0] HADDR_I,
  input wire [1:0] HTRANS_I,
  input wire HWRITE_I,
  input wire HREADY_I,
  input wire [31:0] HRDATA_O,
  input wire HREADYOUT_O,
  input wire HRESP_O,
  // Flash pins
  input wire SEL_N_I,
  input wire RESET_N_I,
  input wire [3:0] DQ_OE_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RSTN_I);
  // Address phase accepted
  wire taken = HSEL_I & HTRANS_I[1] & HREADY_I;
  ready_high_a: assert property (HREADYOUT_O)
    else $error("wait state inserted");
  resp_okay_a: assert property (!HRESP_O)
    else $error("error response");
  unmapped_zero_a: assert property (taken && !HWRITE_I &&
    HADDR_I[7:0] > 8'h18 |=> HRDATA_O == 32'h0)
    else $error("unmapped read not zero");
  write_zero_a: assert property (taken && HWRITE_I |=> HRDATA_O == 32'h0)
    else $error("read data during write");
  rdata_hold_a: assert property (!taken |=> $stable(HRDATA_O))
    else $error("read data moved without request");
  desel_float_a: assert property (
    SEL_N_I [*6] |-> DQ_OE_O == 4'h0)
    else $error("driving while deselected");
  reset_float_a: assert property (
    !RESET_N_I [*6] |-> DQ_OE_O == 4'h0)
    else $error("driving while pin reset low");
  oe_shape_a: assert property (
    DQ_OE_O inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal line enable pattern");
  oe_select_a: assert property ($rose(|DQ_OE_O) |-> !SEL_N_I)
    else $error("output enabled without select");
  // Main scenarios reached
  cover property (taken && !HWRITE_I);
  cover property (DQ_OE_O == 4'hf);
  cover property (DQ_OE_O == 4'h3);
endmodule
bind sfpi_top sfpi_props u_props (.CORE_CLK_I, .RSTN_I, .HSEL_I, .HADDR_I,
  .HTRANS_I, .HWRITE_I, .HREADY_I, .HRDATA_O, .HREADYOUT_O, .HRESP_O,
  .SEL_N_I, .RESET_N_I, .DQ_OE_O);

// ### sfpi_host.sv
// ========================================
// Host controller model
module sfpi_host (
  // Pins toward the device
  output logic sel_n_o,
  output logic sclk_o,
  output wire [3:0] dq_o,
  output logic [3:0] oe_o,
  // Resolved line levels
  input wire [3:0] dq_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic hold_n = 1'b1; // Line three level unless quad data
  logic q = 1'b0; // Line three carries data
  logic [3:0] d = 4'h0; // Data being driven
  assign dq_o = {q ? d[3] : hold_n, d[2:0]};
  initial begin
    sel_n_o = 1'b1;
    sclk_o = 1'b0; // Clock stands low between frames
    oe_o = 4'h8;
  end
  // One frame: nb bits from the top of cmd, then output bits collected
  task automatic frame(input logic [15:0] cmd, input int nb, input int cw,
    input int dw, input bit dr, output logic [7:0] got);
    logic [3:0] b;
    int cb;
    int db;
    cb = 1 << cw;
    db = 1 << dw;
    got = 8'h0;
    // Pin edges land between core clock edges
    #2;
    q = (cw == 2);
    oe_o = q ? 4'hf : (cw == 1 ? 4'hb : 4'h9);
    sel_n_o = 1'b0;
    #40;
    for (int i = 16 - cb; i >= 16 - nb; i -= cb) begin
      d = 4'(cmd >> i);
      #32 sclk_o = 1'b1;
      #32 sclk_o = 1'b0;
    end
    // Line three is held high only for single and dual transfers
    oe_o = (q || dw == 2) ? 4'h0 : 4'h8;
    for (int n = 0; n < 8 / db; n++) begin
      #28 b = dw == 0 ? {3'h0, dq_i[1]} : (dw == 1 ? {2'h0, dq_i[1:0]} : dq_i);
      got = (got << db) | 8'(b);
      #4 sclk_o = ~sclk_o;
      if (!dr && sclk_o) #32 sclk_o = 1'b0;
    end
    #32 sel_n_o = 1'b1;
    q = 1'b0;
    oe_o = 4'h8;
  endtask
endmodule

// ### serial_flash_pin_interface_test.sv
// ========================================
// Register bus bench with host model
module serial_flash_pin_interface_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, hsel = 0, hwrite = 0, rpin_n = 1, wp_n = 1;
  logic flip = 0; // Pattern on released lines
  logic [1:0] htrans = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  logic hready, hresp, h_sel_n, h_sclk;
  logic [3:0] dq_o, dq_oe, h_dq, h_oe, dq_w;
  logic [7:0] got;
  logic [7:0] ctl [6] = '{8'h00, 8'h04, 8'h08, 8'h01, 8'h02, 8'h10};
  int cw [6] = '{0, 0, 0, 1, 2, 0};
  int dw [6] = '{0, 1, 2, 1, 2, 0};
  logic [7:0] pc [4] = '{8'h00, 8'h02, 8'h10, 8'h00};
  logic [7:0] pnv [4] = '{8'h10, 8'h10, 8'h10, 8'h00};
  logic pex [4] = '{1'b1, 1'b0, 1'b0, 1'b0};
  int error_cnt = 0, checked = 0;
  always #4 clk = ~clk;
  always @(posedge clk) flip <= ~flip;
  // Line level from both parties' enables
  assign dq_w = (dq_oe & dq_o) | (~dq_oe & h_oe & h_dq)
    | (~dq_oe & ~h_oe & {4{flip}});
  sfpi_top #(.OP_CYCLES(64)) DUT (.CORE_CLK_I(clk), .RSTN_I(rstn),
    .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .SEL_N_I(h_sel_n), .SCLK_I(h_sclk), .RESET_N_I(rpin_n),
    .PAUSE_N_I(1'b1), .WP_N_I(wp_n), .DQ_I(dq_w), .DQ_O(dq_o),
    .DQ_OE_O(dq_oe));
  sfpi_host host (.sel_n_o(h_sel_n), .sclk_o(h_sclk), .dq_o(h_dq),
    .oe_o(h_oe), .dq_i(dq_w));
  // Single word transfer, read data left in rd
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // Masked register read compare
  task automatic rdm(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic pin_reset;
    @(posedge clk) rpin_n <= 1'b0;
    repeat (8) @(posedge clk);
    rpin_n <= 1'b1;
    repeat (6) @(posedge clk);
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog
  initial begin
    #400000;
    error_cnt++;
    finish_test;
  end
  initial begin
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    rdm(8'h00, 32'hffffffff, 32'h0);
    rdm(8'h04, 32'hffffffff, 32'h10);
    rdm(8'h08, 32'hffffffff, 32'h10);
    rdm(8'h0c, 32'hffffffff, 32'h1a0);
    rdm(8'h14, 32'hffffffff, 32'h0);
    ahb(1'b1, 8'h1c, 32'hffffffff);
    rdm(8'h1c, 32'hffffffff, 32'h0);
    $display("test reset values done");
    ahb(1'b1, 8'h14, 32'hc9);
    for (int i = 0; i < 6; i++) begin
      ahb(1'b1, 8'h00, {24'h0, ctl[i]});
      host.frame({8'h30 + 8'(i), 8'h00}, 8, cw[i], dw[i], i == 5, got);
      chk({24'h0, got}, 32'hc9);
      rdm(8'h18, 32'hff, 32'h30 + i);
    end
    repeat (8) begin
      repeat (4) @(posedge clk);
      host.sclk_o <= ~host.sclk_o;
    end
    rdm(8'h18, 32'hff, 32'h35);
    // One input byte before the output byte
    ahb(1'b1, 8'h00, 32'h0);
    ahb(1'b1, 8'h14, 32'h1c9);
    host.frame(16'h3a5c, 16, 0, 0, 1'b0, got);
    chk({24'h0, got}, 32'hc9);
    rdm(8'h18, 32'hffffff, 32'h15c3a);
    $display("test frames done");
    for (int i = 0; i < 4; i++) begin
      ahb(1'b1, 8'h00, {24'h0, pc[i]});
      ahb(1'b1, 8'h04, {24'h0, pnv[i]});
      @(posedge clk) host.sel_n_o <= 1'b0;
      host.hold_n <= 1'b0;
      repeat (10) @(posedge clk);
      rdm(8'h18, 32'h2000000, 32'(pex[i]) << 25);
      @(posedge clk) host.hold_n <= 1'b1;
      host.sel_n_o <= 1'b1;
    end
    ahb(1'b1, 8'h00, 32'h0);
    ahb(1'b1, 8'h04, 32'h10);
    $display("test pause done");
    ahb(1'b1, 8'h0c, 32'ha4);
    rdm(8'h0c, 32'hfc, 32'ha4);
    @(posedge clk) wp_n <= 1'b0;
    ahb(1'b1, 8'h0c, 32'h0);
    rdm(8'h0c, 32'hfc, 32'ha4);
    ahb(1'b1, 8'h10, 32'h01);
    rdm(8'h18, 32'h8000000, 32'h8000000);
    rdm(8'h0c, 32'h1, 32'h0);
    ahb(1'b1, 8'h10, 32'h11);
    rdm(8'h0c, 32'h101, 32'h1);
    repeat (70) @(posedge clk);
    rdm(8'h0c, 32'h101, 32'h100);
    ahb(1'b1, 8'h10, 32'h11);
    pin_reset;
    rdm(8'h18, 32'h14000000, 32'h14000000);
    rdm(8'h0c, 32'h1, 32'h0);
    ahb(1'b1, 8'h18, 32'h1c000000);
    rdm(8'h18, 32'h1c000000, 32'h0);
    ahb(1'b1, 8'h04, 32'h0);
    pin_reset;
    rdm(8'h18, 32'h4000000, 32'h0);
    $display("test protect and reset done");
    finish_test;
  end
endmodule
